//--- src/tiu_core.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module tiu_core
	import tiu_pkg::*;
#(
	parameter int NUM_FAST = 15
) (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [31:0] boot_addr_i,
	input  wire logic        nonmask_irq_in_i,
	input  wire logic [14:0] irq_fast_i,
	input  wire logic        irq_ext_i,
	input  wire logic        irq_timer_i,
	input  wire logic        irq_soft_i,
	input  wire logic        debug_mode_i,
	input  wire logic        exc_i,
	input  wire logic [4:0]  exc_cause_i,
	input  wire logic [31:0] exc_tval_i,
	input  wire logic [31:0] cur_pc_i,
	input  wire logic        trap_ret_i,
	input  wire logic        load_intg_err_i,
	input  wire logic [31:0] load_addr_i,
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [31:0] reg_rdata_o,
	output logic             redirect_o,
	output logic      [31:0] fetch_addr_o,
	output logic      [1:0]  priv_o,
	output logic             double_fault_o
);
	initial begin
		if (NUM_FAST != 15) $error("tiu_core: NUM_FAST must be 15");
	end

	////////////////////////////////////////////////////////////////////////////
	logic [31:0] vbase_reg, retpc_reg, cause_reg, tval_reg, ien_reg;
	logic        gie_reg, pie_reg, nmi_act_reg, exc_seen_reg, dflt_seen_reg;
	logic [1:0]  priv_reg, pp_reg;
	logic [31:0] bk_retpc_reg, bk_cause_reg;
	logic        bk_pie_reg;
	logic [1:0]  bk_pp_reg;
	logic        int_irq_reg;
	logic [31:0] int_tval_reg;
	logic        boot_reg;

	// pending view excludes the nonmask line
	wire [31:0] pend_w = {1'b0, irq_fast_i, 4'h0, irq_ext_i, 3'h0,
	                      irq_timer_i, 3'h0, irq_soft_i, 3'h0};
	wire [31:0] live_w = pend_w & ien_reg & {32{gie_reg}};
	// debug and nonmask handler both mute every source
	wire        mute_w = debug_mode_i | nmi_act_reg;
	wire        nmi_w  = ~mute_w & (nonmask_irq_in_i | int_irq_reg);

	// fast first, lowest fast first, then standard order ext, sw, timer
	logic [4:0] irq_id_w;
	logic       irq_any_w;
	always_comb begin
		irq_id_w  = TIU_ID_EXT;
		irq_any_w = 1'b0;
		if (live_w[TIU_B_TMR]) begin
			irq_id_w  = TIU_ID_TMR;
			irq_any_w = 1'b1;
		end
		if (live_w[TIU_B_SW]) begin
			irq_id_w  = TIU_ID_SW;
			irq_any_w = 1'b1;
		end
		if (live_w[TIU_B_EXT]) begin
			irq_id_w  = TIU_ID_EXT;
			irq_any_w = 1'b1;
		end
		for (int i = NUM_FAST - 1; i >= 0; i--) begin
			if (live_w[TIU_B_FAST + i]) begin
				irq_id_w  = TIU_ID_FAST0 + 5'(i);
				irq_any_w = 1'b1;
			end
		end
	end

	// exceptions are never masked; they win over interrupts in the same cycle
	wire take_exc_w = exc_i;
	wire take_nmi_w = ~exc_i & nmi_w;
	wire take_irq_w = ~exc_i & ~nmi_w & irq_any_w & ~mute_w;
	wire take_w     = take_exc_w | take_nmi_w | take_irq_w;
	wire dfault_w   = exc_i & exc_seen_reg;

	wire [31:0] nmi_cause_w = nonmask_irq_in_i ? TIU_CAUSE_XNMI : TIU_CAUSE_LINTG;
	wire [31:0] new_cause_w = take_exc_w ? {27'h0, exc_cause_i} :
	                          take_nmi_w ? nmi_cause_w : (TIU_IRQ_FLAG | {27'h0, irq_id_w});
	wire [4:0]  vec_id_w    = take_nmi_w ? TIU_ID_NMI : irq_id_w;
	wire [31:0] vec_w       = take_exc_w ? vbase_reg :
	                          vbase_reg + {25'h0, vec_id_w, 2'b00};

	wire sw_we_w = reg_we_i;
	wire [31:0] status_w = 32'(gie_reg) << TIU_ST_GIE | 32'(pie_reg) << TIU_ST_PIE |
	                       32'(pp_reg) << TIU_ST_PP;
	logic [31:0] rd_w;
	always_comb begin
		case (reg_addr_i)
			TIU_A_STATUS:  rd_w = status_w;
			TIU_A_IENABLE: rd_w = ien_reg;
			TIU_A_VBASE:   rd_w = vbase_reg;
			TIU_A_RETPC:   rd_w = retpc_reg;
			TIU_A_CAUSE:   rd_w = cause_reg;
			TIU_A_TVAL:    rd_w = tval_reg;
			TIU_A_PEND:    rd_w = pend_w;
			TIU_A_CTRL:    rd_w = {30'h0, dflt_seen_reg, exc_seen_reg};
			default:       rd_w = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			gie_reg <= 1'b0;
			ien_reg <= 32'h0;
			pie_reg <= 1'b0;
			pp_reg <= TIU_PRIV_M;
			priv_reg <= TIU_PRIV_M;
			vbase_reg <= 32'h0;
			retpc_reg <= 32'h0;
			cause_reg <= 32'h0;
			tval_reg <= 32'h0;
			nmi_act_reg <= 1'b0;
			exc_seen_reg <= 1'b0;
			dflt_seen_reg <= 1'b0;
			double_fault_o <= 1'b0;
			bk_retpc_reg <= 32'h0;
			bk_cause_reg <= 32'h0;
			bk_pie_reg <= 1'b0;
			bk_pp_reg <= TIU_PRIV_M;
			int_irq_reg <= 1'b0;
			int_tval_reg <= 32'h0;
			boot_reg <= 1'b1;
			redirect_o <= 1'b0;
			fetch_addr_o <= 32'h0;
			reg_rdata_o <= 32'h0;
		end else begin
			boot_reg <= 1'b0;
			reg_rdata_o <= reg_re_i ? rd_w : 32'h0;
			redirect_o <= boot_reg | take_w | trap_ret_i;
			double_fault_o <= dfault_w;
			if (sw_we_w && reg_addr_i == TIU_A_STATUS) begin
				gie_reg <= reg_wdata_i[TIU_ST_GIE];
				pie_reg <= reg_wdata_i[TIU_ST_PIE];
				pp_reg <= reg_wdata_i[TIU_ST_PP+:2] == TIU_PRIV_U ? TIU_PRIV_U : TIU_PRIV_M;
			end
			if (sw_we_w && reg_addr_i == TIU_A_IENABLE)
				ien_reg <= reg_wdata_i & 32'hFFFF0888;
			if (sw_we_w && reg_addr_i == TIU_A_VBASE)
				vbase_reg <= reg_wdata_i;
			if (sw_we_w && reg_addr_i == TIU_A_RETPC)
				retpc_reg <= reg_wdata_i;
			// software write to the flag leaves the output pulse alone
			if (sw_we_w && reg_addr_i == TIU_A_CTRL)
				dflt_seen_reg <= reg_wdata_i[1];
			// integrity error latched; set beats the entry clear
			if (take_nmi_w && !nonmask_irq_in_i)
				int_irq_reg <= 1'b0;
			if (load_intg_err_i) begin
				int_irq_reg <= 1'b1;
				int_tval_reg <= load_addr_i;
			end
			if (boot_reg) begin
				vbase_reg <= boot_addr_i;
				fetch_addr_o <= {boot_addr_i[31:8], TIU_BOOT_LOW};
			end else if (take_w) begin
				bk_retpc_reg <= retpc_reg;
				bk_cause_reg <= cause_reg;
				bk_pie_reg <= pie_reg;
				bk_pp_reg <= pp_reg;
				retpc_reg <= cur_pc_i;
				pie_reg <= gie_reg;
				pp_reg <= priv_reg;
				gie_reg <= 1'b0;
				priv_reg <= TIU_PRIV_M;
				cause_reg <= new_cause_w;
				tval_reg <= take_exc_w ? exc_tval_i :
				            (take_nmi_w && !nonmask_irq_in_i) ? int_tval_reg : 32'h0;
				fetch_addr_o <= vec_w;
				if (take_nmi_w)
					nmi_act_reg <= 1'b1;
				if (take_exc_w)
					exc_seen_reg <= 1'b1;
				if (dfault_w)
					dflt_seen_reg <= 1'b1;
			end else if (trap_ret_i) begin
				fetch_addr_o <= retpc_reg;
				gie_reg <= pie_reg;
				priv_reg <= pp_reg;
				pie_reg <= 1'b1;
				pp_reg <= TIU_PRIV_U;
				exc_seen_reg <= 1'b0;
				// leaving a nonmask handler restores return pc, cause, pie and pp from the hidden copies; tval is not restored
				if (nmi_act_reg) begin
					nmi_act_reg <= 1'b0;
					retpc_reg <= bk_retpc_reg;
					cause_reg <= bk_cause_reg;
					pie_reg <= bk_pie_reg;
					pp_reg <= bk_pp_reg;
				end
			end
		end
	end

	assign priv_o = priv_reg;

	////////////////////////////////////////////////////////////////////////////
	a_exc_vector: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && exc_i |=> redirect_o && fetch_addr_o == $past(vbase_reg))
		else $error("exception vector wrong");
	a_irq_vector: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && take_irq_w |=> fetch_addr_o == $past(vbase_reg) + {$past(irq_id_w), 2'b00})
		else $error("interrupt vector wrong");
	a_gie_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && take_w |=> !gie_reg && priv_reg == TIU_PRIV_M)
		else $error("enable not cleared on trap");
	a_debug_mute: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		debug_mode_i |-> !take_nmi_w && !take_irq_w)
		else $error("interrupt taken in debug");
	a_nmi_mute: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		nmi_act_reg |-> !take_nmi_w && !take_irq_w)
		else $error("interrupt inside nonmask handler");
	a_dfault_pulse: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		double_fault_o |-> $past(exc_i) && $past(exc_seen_reg))
		else $error("double fault pulse too long");
	a_dfault_cause: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		exc_i && exc_seen_reg |=> double_fault_o && dflt_seen_reg)
		else $error("double fault missed");
	a_ret_restore: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && !take_w && trap_ret_i |=> fetch_addr_o == $past(retpc_reg)
		&& gie_reg == $past(pie_reg))
		else $error("trap return wrong");
	a_entry_save: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && take_w |=> retpc_reg == $past(cur_pc_i) && pie_reg == $past(gie_reg))
		else $error("trap entry save wrong");

	////////////////////////////////////////////////////////////////////////////
	// nonmask and internal entries; only the internal-take step is shared, by two checks
	sequence s_nmi_take;
		!boot_reg && take_nmi_w;
	endsequence
	sequence s_nmi_land;
		redirect_o && nmi_act_reg && priv_reg == TIU_PRIV_M;
	endsequence
	sequence s_nmi_slot;
		fetch_addr_o == $past(vbase_reg) + {25'h0, TIU_ID_NMI, 2'b00};
	endsequence
	sequence s_intg_take;
		!boot_reg && take_nmi_w && !nonmask_irq_in_i;
	endsequence
	sequence s_xnmi_take;
		!boot_reg && take_nmi_w && nonmask_irq_in_i;
	endsequence

	a_nmi_vector: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_nmi_take |=> s_nmi_land ##0 s_nmi_slot)
		else $error("nonmask vector wrong");

	a_intg_report: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_intg_take |=> cause_reg == TIU_CAUSE_LINTG
		&& tval_reg == $past(int_tval_reg))
		else $error("internal interrupt report wrong");

	// a new error in the entry cycle must survive the clear
	a_intg_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_intg_take ##0 !load_intg_err_i |=> !int_irq_reg)
		else $error("internal interrupt not cleared");

	a_xnmi_cause: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		s_xnmi_take |=> cause_reg == TIU_CAUSE_XNMI)
		else $error("external nonmask cause wrong");

	a_intg_raise: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		load_intg_err_i |=> int_irq_reg && int_tval_reg == $past(load_addr_i))
		else $error("integrity error not latched");

	////////////////////////////////////////////////////////////////////////////
	// boot: one redirect, vector base from the same sampled address
	a_boot_fetch: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		boot_reg |=> redirect_o && fetch_addr_o == {$past(boot_addr_i[31:8]), TIU_BOOT_LOW})
		else $error("boot fetch wrong");

	a_boot_vbase: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		boot_reg |=> vbase_reg == $past(boot_addr_i))
		else $error("boot vector base wrong");

	////////////////////////////////////////////////////////////////////////////
	// return and the hidden copies
	property p_ret_priv;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && !take_w && trap_ret_i |=> priv_reg == $past(pp_reg);
	endproperty
	a_priv_return: assert property (p_ret_priv)
		else $error("return privilege wrong");

	property p_backup_save;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && take_w |=> bk_retpc_reg == $past(retpc_reg) && bk_cause_reg == $past(cause_reg)
			&& bk_pie_reg == $past(pie_reg) && bk_pp_reg == $past(pp_reg);
	endproperty
	a_backup_save: assert property (p_backup_save)
		else $error("backup copy wrong");

	property p_nmi_restore;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && !take_w && trap_ret_i && nmi_act_reg |=> !nmi_act_reg
			&& retpc_reg == $past(bk_retpc_reg) && cause_reg == $past(bk_cause_reg);
	endproperty
	a_nmi_restore: assert property (p_nmi_restore)
		else $error("nonmask return restore wrong");

	////////////////////////////////////////////////////////////////////////////
	// masking and priority
	a_mask_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		take_irq_w |-> gie_reg && (pend_w & ien_reg) != 32'h0)
		else $error("masked interrupt taken");

	a_fast_first: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		take_irq_w && |live_w[TIU_B_FAST+:NUM_FAST] |-> irq_id_w >= TIU_ID_FAST0)
		else $error("fast line lost priority");

	// an unmuted nonmask request always beats the maskable ones
	a_nmi_top: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		nonmask_irq_in_i && !mute_w && !exc_i |-> take_nmi_w && !take_irq_w)
		else $error("nonmask lost priority");

	////////////////////////////////////////////////////////////////////////////
	// exception flag, privilege on entry and double fault
	a_exc_flag: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && exc_i |=> exc_seen_reg)
		else $error("exception flag not set");

	a_ret_flag: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && !take_w && trap_ret_i |=> !exc_seen_reg)
		else $error("exception flag not cleared");

	// only a double fault raises the pulse; a flag write never does
	a_dfault_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!(exc_i && exc_seen_reg) |=> !double_fault_o)
		else $error("spurious double fault pulse");

	a_priv_entry: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!boot_reg && take_w |=> priv_reg == TIU_PRIV_M && pp_reg == $past(priv_reg))
		else $error("entry privilege wrong");
endmodule : tiu_core

//--- common/tiu_pkg.sv
package tiu_pkg;
	localparam logic [1:0]  TIU_PRIV_M = 2'h3;
	localparam logic [1:0]  TIU_PRIV_U = 2'h0;
	localparam logic [4:0]  TIU_ID_NMI = 5'h1F;
	localparam logic [4:0]  TIU_ID_FAST0 = 5'h10;
	localparam logic [4:0]  TIU_ID_EXT = 5'h0B;
	localparam logic [4:0]  TIU_ID_TMR = 5'h07;
	localparam logic [4:0]  TIU_ID_SW = 5'h03;
	localparam logic [7:0]  TIU_BOOT_LOW = 8'h80;
	localparam logic [31:0] TIU_CAUSE_LINTG = 32'hFFFFFFE0;
	localparam logic [31:0] TIU_CAUSE_XNMI = 32'h00008000;
	localparam logic [31:0] TIU_IRQ_FLAG = 32'h80000000;
	localparam logic [4:0]  TIU_EXC_IFAULT = 5'h01;
	localparam logic [4:0]  TIU_EXC_ILLEGAL = 5'h02;
	localparam logic [4:0]  TIU_EXC_BREAK = 5'h03;
	localparam logic [4:0]  TIU_EXC_LFAULT = 5'h05;
	localparam logic [4:0]  TIU_EXC_SFAULT = 5'h07;
	localparam logic [4:0]  TIU_EXC_ENVIRONMENT_CALL_U = 5'h08;
	localparam logic [4:0]  TIU_EXC_ENVIRONMENT_CALL_M = 5'h0B;
	// register port indices
	localparam logic [2:0]  TIU_A_STATUS = 3'h0;
	localparam logic [2:0]  TIU_A_IENABLE = 3'h1;
	localparam logic [2:0]  TIU_A_VBASE = 3'h2;
	localparam logic [2:0]  TIU_A_RETPC = 3'h3;
	localparam logic [2:0]  TIU_A_CAUSE = 3'h4;
	localparam logic [2:0]  TIU_A_TVAL = 3'h5;
	localparam logic [2:0]  TIU_A_PEND = 3'h6;
	localparam logic [2:0]  TIU_A_CTRL = 3'h7;
	// status fields
	localparam int TIU_ST_GIE = 3;
	localparam int TIU_ST_PIE = 7;
	localparam int TIU_ST_PP = 11;
	// pending/enable bit positions
	localparam int TIU_B_SW = 3;
	localparam int TIU_B_TMR = 7;
	localparam int TIU_B_EXT = 11;
	localparam int TIU_B_FAST = 16;
endpackage : tiu_pkg

//--- verif/tiu_irq_src.sv
`timescale 1ns/10ps
module tiu_irq_src (
	input  wire logic        sys_clk_i,
	input  wire logic        nrst_i,
	input  wire logic [31:0] raise_i,
	input  wire logic [31:0] ack_i,
	output logic      [31:0] lines_o
);
	logic [31:0] lines_reg;
	// bit n is the line of identifier n; a line stays up until acknowledged
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			lines_reg <= 32'h00000000;
		end else begin
			lines_reg <= (lines_reg | raise_i) & ~ack_i;
		end
	end
	assign lines_o = lines_reg;
endmodule : tiu_irq_src

//--- verif/test_trap_and_interrupt_unit.sv
`timescale 1ns/10ps
module test_trap_and_interrupt_unit import tiu_pkg::*; ;
	logic        clk, nrst, dbg, exc, tret, lerr, we, re, redir, df;
	logic [4:0]  ec;
	logic [2:0]  ra;
	logic [1:0]  priv;
	logic [31:0] boot, tval, pc, laddr, wd, rdata, faddr, raise, ack, lines;
	logic [31:0] rv, vb, rpc, pend;
	int          num_errors, tests_run, id;
	logic [4:0]  causes[7] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h07, 5'h08, 5'h0B};
	tiu_core dut (.sys_clk_i(clk), .nrst_i(nrst), .boot_addr_i(boot), .nonmask_irq_in_i(lines[31]),
		.irq_fast_i(lines[30:16]), .irq_ext_i(lines[11]), .irq_timer_i(lines[7]),
		.irq_soft_i(lines[3]), .debug_mode_i(dbg), .exc_i(exc), .exc_cause_i(ec),
		.exc_tval_i(tval), .cur_pc_i(pc), .trap_ret_i(tret), .load_intg_err_i(lerr),
		.load_addr_i(laddr), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re),
		.reg_rdata_o(rdata), .redirect_o(redir), .fetch_addr_o(faddr), .priv_o(priv),
		.double_fault_o(df));
	tiu_irq_src src (.sys_clk_i(clk), .nrst_i(nrst), .raise_i(raise), .ack_i(ack), .lines_o(lines));
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic [2:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		ra <= a;
		wd <= d;
		we <= w;
		re <= !w;
		@(posedge clk);
		we <= 1'b0;
		re <= 1'b0;
		#1 rv = rdata;
	endtask : bus
	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0) exc <= 1'b1;
		if (k == 1) tret <= 1'b1;
		if (k == 2) lerr <= 1'b1;
		@(posedge clk);
		exc <= 1'b0;
		tret <= 1'b0;
		lerr <= 1'b0;
		// the internal request is latched first, so its entry lands one edge later
		if (k == 2) @(posedge clk);
		#1 chk("redirect", 32'h1, {31'h0, redir});
	endtask : pulse
	task automatic take(input logic [31:0] exp);
		// step past any redirect still standing from the previous return
		@(posedge clk);
		#1;
		for (int i = 0; i < 8 && redir !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		rpc = pc;
		chk("irq fetch", exp, faddr);
		chk("irq priv", {30'h0, TIU_PRIV_M}, {30'h0, priv});
	endtask : take
	task automatic quiet();
		repeat (6) begin
			@(posedge clk);
			#1 chk("no redirect", 32'h0, {31'h0, redir});
		end
	endtask : quiet
	task automatic line(input logic [31:0] up, input logic [31:0] dn);
		@(posedge clk);
		raise <= up;
		ack <= dn;
		@(posedge clk);
		raise <= 32'h0;
		ack <= 32'h0;
	endtask : line
	function automatic int nxt(input logic [31:0] p);
		for (int i = 16; i < 31; i++) if (p[i]) return i;
		return p[11] ? 11 : (p[3] ? 3 : 7);
	endfunction : nxt
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		results();
	end
	initial begin
		{clk, nrst, dbg, exc, tret, lerr, we, re, ec, ra, wd, raise, ack} = '0;
		void'($urandom(32'h5040da77));
		boot = $urandom & 32'hFFFFFF00;
		{pc, tval, laddr} = {$urandom, $urandom, $urandom};
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1 chk("boot fetch", {boot[31:8], 8'h80}, faddr);
		chk("reset priv", {30'h0, TIU_PRIV_M}, {30'h0, priv});
		bus(TIU_A_VBASE, 0, 0);
		chk("vbase", boot, rv);
		bus(TIU_A_IENABLE, 0, 0);
		chk("ienable", 32'h0, rv);
		vb = $urandom & 32'hFFFFFF00;
		bus(TIU_A_VBASE, vb, 1);
		foreach (causes[i]) begin
			ec <= causes[i];
			pc <= $urandom;
			pulse(0);
			chk("exc fetch", vb, faddr);
			chk("exc priv", {30'h0, TIU_PRIV_M}, {30'h0, priv});
			bus(TIU_A_CAUSE, 0, 0);
			chk("cause", {27'h0, causes[i]}, rv);
			bus(TIU_A_RETPC, 0, 0);
			chk("retpc", pc, rv);
			bus(TIU_A_STATUS, 32'h80, 1);
			pulse(1);
			chk("ret fetch", pc, faddr);
			chk("ret priv", {30'h0, TIU_PRIV_U}, {30'h0, priv});
		end
		ec <= TIU_EXC_ILLEGAL;
		pulse(0);
		pulse(0);
		chk("double fault", 32'h1, {31'h0, df});
		@(posedge clk);
		#1 chk("double fault end", 32'h0, {31'h0, df});
		bus(TIU_A_CTRL, 0, 0);
		chk("ctrl", 32'h3, rv & 32'h3);
		pulse(1);
		bus(TIU_A_CTRL, 0, 0);
		chk("ctrl ret", 32'h0, rv & 32'h1);
		bus(TIU_A_STATUS, 32'h1808, 1);
		bus(TIU_A_IENABLE, 32'h0, 1);
		pend = {1'b0, 15'($urandom_range(1, 32767)), 16'h0888};
		line(pend, 0);
		quiet();
		bus(TIU_A_IENABLE, 32'hFFFF0888, 1);
		while (pend != 0) begin
			id = nxt(pend);
			take(vb + 4 * id);
			bus(TIU_A_STATUS, 0, 0);
			chk("status", 32'h80, rv & 32'h88);
			bus(TIU_A_CAUSE, 0, 0);
			chk("irq cause", TIU_IRQ_FLAG | id, rv);
			line(0, 1 << id);
			pend[id] = 1'b0;
			pulse(1);
			chk("irq ret", rpc, faddr);
		end
		bus(TIU_A_STATUS, 32'h1800, 1);
		line(32'h80000000, 0);
		take(vb + 32'h7C);
		bus(TIU_A_CAUSE, 0, 0);
		chk("nmi cause", TIU_CAUSE_XNMI, rv);
		bus(TIU_A_PEND, 0, 0);
		chk("nmi hidden", 32'h0, rv & TIU_IRQ_FLAG);
		quiet();
		line(0, 32'h80000000);
		pulse(1);
		dbg <= 1'b1;
		line(32'h80000000, 0);
		quiet();
		line(0, 32'h80000000);
		dbg <= 1'b0;
		pulse(2);
		chk("intg fetch", vb + 32'h7C, faddr);
		bus(TIU_A_CAUSE, 0, 0);
		chk("intg cause", TIU_CAUSE_LINTG, rv);
		bus(TIU_A_TVAL, 0, 0);
		chk("intg tval", laddr, rv);
		pulse(1);
		quiet();
		results();
	end
endmodule : test_trap_and_interrupt_unit
